// ===== verilog/scr_pkg.sv
// Package with offsets, fields and constants of the system control registers
`default_nettype none
package scr_pkg;
    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] VTBO_OFF = 8'h08;
    localparam logic [7:0] AIRC_OFF = 8'h0c;
    localparam logic [7:0] LPC_OFF  = 8'h10;
    localparam logic [7:0] CFG_OFF  = 8'h14;
    localparam logic [7:0] HPR2_OFF = 8'h1c;
    localparam logic [7:0] HPR3_OFF = 8'h20;

    // ------------------------------------------------------------
    // Field positions and values
    // ------------------------------------------------------------
    localparam int          TBL_LSB     = 7;
    localparam int          KEY_LSB     = 16;
    localparam logic [15:0] WRITE_KEY   = 16'h05fa;
    localparam int          ORDER_BIT   = 15;
    localparam int          SYSRST_BIT  = 2;
    localparam int          EVPEND_BIT  = 4;
    localparam int          DEEP_BIT    = 2;
    localparam int          ONRET_BIT   = 1;
    localparam int          ALIGN_BIT   = 9;
    localparam int          TRAP_BIT    = 3;
    localparam int          PRI_A_LSB   = 30;
    localparam int          PRI_B_LSB   = 22;
    localparam logic [31:0] VTBO_RESET  = 32'h0000_0000;
    localparam logic [1:0]  PRI_RESET   = 2'h0;
    localparam logic [7:0]  RST_PULSE_CYC = 8'h04;
    localparam logic [1:0]  HTRANS_NSEQ = 2'h2;
    localparam logic [2:0]  HSIZE_WORD  = 3'h2;
endpackage : scr_pkg
`default_nettype wire

// ===== verilog/scr_event_latch.sv
// Wake event latch and wake pulse generator
`timescale 1ns/1ps
`default_nettype none
module scr_event_latch (
    input  wire logic hclk,
    input  wire logic hresetn,
    input  wire logic event_on_pending,
    input  wire logic irq_pending_enabled,
    input  wire logic irq_pending_disabled,
    input  wire logic send_event_instruction,
    input  wire logic external_event,
    input  wire logic wait_for_event,
    output var  logic event_latched,
    output var  logic wake
);
    logic pend_event;
    logic any_event;

    // ------------------------------------------------------------
    // Event sources
    // ------------------------------------------------------------
    // Disabled interrupts only count when event on pending is set
    assign pend_event = irq_pending_enabled |
                        (event_on_pending & irq_pending_disabled); // [R6]
    assign any_event  = pend_event | send_event_instruction
                        | external_event; // [R8]

    // Latch events while not waiting; waiting clears the latch, even with a new event
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            event_latched <= 1'b0;
        end else if (any_event && !wait_for_event) begin
            event_latched <= 1'b1; // [R7]
        end else if (wait_for_event) begin
            event_latched <= 1'b0;
        end
    end

    // Wake pulse on live or remembered event while waiting
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wake <= 1'b0;
        end else begin
            wake <= wait_for_event & (any_event | event_latched); // [R7]
        end
    end
endmodule : scr_event_latch
`default_nettype wire

// ===== verilog/scr_regs.sv
// System control register bank with AHB-Lite slave
//
// Contract
// [R1] Vector offset holds bits 31:7 only
// [R2] Reset control write needs key 0x05FA
// [R3] Byte order bit reads zero, little-endian
// [R4] Writing 1 requests system reset
// [R5] Software writes zero to debug bit
// [R6] Event on pending admits disabled interrupts
// [R7] Pending event wakes or is latched
// [R8] Send event or external event wakes
// [R9] Deep select chooses sleep or deep
// [R10] Sleep on handler return when set
// [R11] Configuration register is read-only
// [R12] Stack alignment bit reads one
// [R13] Stacked status bit 9 records padding
// [R14] Misaligned trap bit reads one
// [R15] Priorities implement bits 7:6 only
// [R16] Priority values range 0 to 192
// [R17] Register two holds supervisor call priority
// [R18] Register three holds tick, pendable priorities
// [R19] Tick priority reserved without tick timer
// [R20] Software uses word access for priorities
// [R21] Reserved bits read zero, ignore writes
//
// The placing of the registers and register access over AHB-Lite were decided locally.
`timescale 1ns/1ps
`default_nettype none
module scr_regs #(
    parameter bit HAS_TICK_TIMER = 1'b1
) (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output var  logic [31:0] hrdata,
    output var  logic        hreadyout,
    output var  logic        hresp,
    input  wire logic        irq_pending_enabled,
    input  wire logic        irq_pending_disabled,
    input  wire logic        send_event_instruction,
    input  wire logic        external_event,
    input  wire logic        wait_for_event,
    input  wire logic        handler_return_to_thread,
    input  wire logic        exc_entry,
    input  wire logic        exc_return,
    input  wire logic        sp_bit2,
    input  wire logic        stacked_psr_bit9,
    input  wire logic        access_misaligned,
    output var  logic        wake,
    output var  logic        event_latched,
    output var  logic        sleep_req,
    output var  logic        deep_sleep_req,
    output var  logic        system_reset_request,
    output var  logic        hard_fault_exception,
    output var  logic        stacked_align_pad,
    output var  logic        return_align_pad,
    output var  logic [31:0] vector_table_base,
    output var  logic [1:0]  supervisor_call_priority,
    output var  logic [1:0]  pendable_service_priority,
    output var  logic [1:0]  tick_timer_priority
);
    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    logic [24:0] table_base_offset_field_reg;
    logic        event_on_pending_reg;
    logic        deep_low_power_select_reg;
    logic        low_power_on_handler_return_reg;
    logic [1:0]  pri_svc_reg;
    logic [1:0]  pri_pend_reg;
    logic [1:0]  pri_tick_reg;
    logic [7:0]  rst_cnt_reg;
    logic        wr_pend_reg;
    logic [7:0]  wr_off_reg;
    logic        wr_word_reg;
    logic        addr_ok;
    logic        wr_fire;
    logic        rd_fire;
    logic [31:0] rd_next;

    // ------------------------------------------------------------
    // Bus address phase
    // ------------------------------------------------------------
    assign addr_ok = hsel && hready && (htrans == scr_pkg::HTRANS_NSEQ);
    assign wr_fire = addr_ok && hwrite;
    assign rd_fire = addr_ok && !hwrite;

    // Pending flag marks the data phase of a write
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
        end else begin
            wr_pend_reg <= wr_fire;
        end
    end

    // Capture write address; data arrives in the next cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_off_reg  <= 8'h00;
            wr_word_reg <= 1'b0;
        end else if (wr_fire) begin
            wr_off_reg  <= {haddr[7:2], 2'b00};
            wr_word_reg <= (hsize == scr_pkg::HSIZE_WORD);
        end
    end

    // Zero wait states
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
        end else begin
            hreadyout <= 1'b1;
        end
    end

    // Always OKAY; bad accesses are dropped, not refused
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hresp <= 1'b0;
        end else begin
            hresp <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------
    // Unmapped offsets, key field and reserved bits read zero
    always_comb begin
        rd_next = 32'h0000_0000; // [R21]
        unique case ({haddr[7:2], 2'b00})
            scr_pkg::VTBO_OFF:
                rd_next[31:scr_pkg::TBL_LSB] =
                    table_base_offset_field_reg; // [R1]
            scr_pkg::AIRC_OFF: begin
                rd_next[scr_pkg::ORDER_BIT]  = 1'b0; // [R3]
                rd_next[scr_pkg::SYSRST_BIT] = 1'b0; // [R4]
            end
            scr_pkg::LPC_OFF: begin
                rd_next[scr_pkg::EVPEND_BIT] = event_on_pending_reg;
                rd_next[scr_pkg::DEEP_BIT]   = deep_low_power_select_reg;
                rd_next[scr_pkg::ONRET_BIT]  =
                    low_power_on_handler_return_reg;
            end
            scr_pkg::CFG_OFF: begin // [R11]
                rd_next[scr_pkg::ALIGN_BIT] = 1'b1; // [R12]
                rd_next[scr_pkg::TRAP_BIT]  = 1'b1; // [R14]
            end
            scr_pkg::HPR2_OFF:
                rd_next[scr_pkg::PRI_A_LSB +: 2] = pri_svc_reg; // [R17]
            scr_pkg::HPR3_OFF: begin
                rd_next[scr_pkg::PRI_A_LSB +: 2] = pri_tick_reg; // [R18]
                rd_next[scr_pkg::PRI_B_LSB +: 2] = pri_pend_reg;
            end
            default: rd_next = 32'h0000_0000;
        endcase
    end

    // Read data registered at end of address phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (rd_fire) begin
            hrdata <= rd_next;
        end
    end

    // ------------------------------------------------------------
    // Writable registers
    // ------------------------------------------------------------
    // Vector table offset; low seven bits not stored
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            table_base_offset_field_reg <=
                scr_pkg::VTBO_RESET[31:scr_pkg::TBL_LSB];
        end else if (wr_pend_reg && wr_off_reg == scr_pkg::VTBO_OFF) begin
            table_base_offset_field_reg <=
                hwdata[31:scr_pkg::TBL_LSB]; // [R1]
        end
    end

    // Low-power control bits
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            event_on_pending_reg            <= 1'b0;
            deep_low_power_select_reg       <= 1'b0;
            low_power_on_handler_return_reg <= 1'b0;
        end else if (wr_pend_reg && wr_off_reg == scr_pkg::LPC_OFF) begin
            event_on_pending_reg <= hwdata[scr_pkg::EVPEND_BIT]; // [R6]
            deep_low_power_select_reg <= hwdata[scr_pkg::DEEP_BIT]; // [R9]
            low_power_on_handler_return_reg <=
                hwdata[scr_pkg::ONRET_BIT]; // [R10]
        end
    end

    // Priorities keep bits 7:6 only; sub-word writes dropped
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pri_svc_reg <= scr_pkg::PRI_RESET;
        end else if (wr_pend_reg && wr_word_reg
                     && wr_off_reg == scr_pkg::HPR2_OFF) begin // [R20]
            pri_svc_reg <= hwdata[scr_pkg::PRI_A_LSB +: 2]; // [R15]
        end
    end

    // Pendable service priority in register three
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pri_pend_reg <= scr_pkg::PRI_RESET;
        end else if (wr_pend_reg && wr_word_reg
                     && wr_off_reg == scr_pkg::HPR3_OFF) begin
            pri_pend_reg <= hwdata[scr_pkg::PRI_B_LSB +: 2]; // [R16]
        end
    end

    // Tick priority stays zero when no tick timer is built
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pri_tick_reg <= scr_pkg::PRI_RESET;
        end else if (HAS_TICK_TIMER && wr_pend_reg && wr_word_reg
                     && wr_off_reg == scr_pkg::HPR3_OFF) begin // [R19]
            pri_tick_reg <= hwdata[scr_pkg::PRI_A_LSB +: 2];
        end
    end

    // Keyed reset request; counter sets the pulse length
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rst_cnt_reg <= 8'h00;
        end else if (wr_pend_reg && wr_off_reg == scr_pkg::AIRC_OFF
                && hwdata[31:scr_pkg::KEY_LSB] == scr_pkg::WRITE_KEY // [R2]
                && hwdata[scr_pkg::SYSRST_BIT]) begin
            rst_cnt_reg <= scr_pkg::RST_PULSE_CYC; // [R4]
        end else if (rst_cnt_reg != 8'h00) begin
            rst_cnt_reg <= rst_cnt_reg - 8'h01;
        end
    end

    // Request follows the counter, so it leaves a flop
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            system_reset_request <= 1'b0;
        end else begin
            system_reset_request <= (rst_cnt_reg != 8'h00); // [R4]
        end
    end

    // ------------------------------------------------------------
    // Core-facing outputs
    // ------------------------------------------------------------
    // Sleep entry on return to thread; mode picks deep or normal
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sleep_req <= 1'b0;
        end else begin
            sleep_req <= handler_return_to_thread
                & low_power_on_handler_return_reg
                & !deep_low_power_select_reg; // [R10]
        end
    end

    // Deep sleep takes the same trigger with the deep bit set
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            deep_sleep_req <= 1'b0;
        end else begin
            deep_sleep_req <= handler_return_to_thread
                & low_power_on_handler_return_reg
                & deep_low_power_select_reg; // [R9]
        end
    end

    // Alignment padding recorded on exception entry
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            stacked_align_pad <= 1'b0;
        end else if (exc_entry) begin
            stacked_align_pad <= sp_bit2; // [R13]
        end
    end

    // Stacked bit handed back on return to restore alignment
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            return_align_pad <= 1'b0;
        end else if (exc_return) begin
            return_align_pad <= stacked_psr_bit9; // [R13]
        end
    end

    // Trap is fixed on, so every misaligned access faults
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hard_fault_exception <= 1'b0;
        end else begin
            hard_fault_exception <= access_misaligned; // [R14]
        end
    end

    // Vector base mirror; low seven bits always zero
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            vector_table_base <= scr_pkg::VTBO_RESET;
        end else begin
            vector_table_base <= {table_base_offset_field_reg, 7'h00};
        end
    end

    // Priority mirrors for the exception logic
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            supervisor_call_priority  <= scr_pkg::PRI_RESET;
            pendable_service_priority <= scr_pkg::PRI_RESET;
            tick_timer_priority       <= scr_pkg::PRI_RESET;
        end else begin
            supervisor_call_priority  <= pri_svc_reg;
            pendable_service_priority <= pri_pend_reg;
            tick_timer_priority       <= pri_tick_reg;
        end
    end

    // ------------------------------------------------------------
    // Wake logic
    // ------------------------------------------------------------
    scr_event_latch u_event (
        .hclk                   (hclk),
        .hresetn                (hresetn),
        .event_on_pending       (event_on_pending_reg),
        .irq_pending_enabled    (irq_pending_enabled),
        .irq_pending_disabled   (irq_pending_disabled),
        .send_event_instruction (send_event_instruction),
        .external_event         (external_event),
        .wait_for_event         (wait_for_event),
        .event_latched          (event_latched),
        .wake                   (wake)
    ); // [R7]
endmodule : scr_regs
`default_nettype wire

// ===== dv/scr_regs_properties.sv
// Concurrent checks on the system control register bank ports
`timescale 1ns/1ps
`default_nettype none
module scr_regs_properties (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic wait_for_event,
    input wire logic irq_pending_enabled,
    input wire logic send_event_instruction,
    input wire logic external_event,
    input wire logic handler_return_to_thread,
    input wire logic exc_entry,
    input wire logic sp_bit2,
    input wire logic access_misaligned,
    input wire logic wake,
    input wire logic sleep_req,
    input wire logic deep_sleep_req,
    input wire logic system_reset_request,
    input wire logic hard_fault_exception,
    input wire logic stacked_align_pad
);
    // ----------------------------------------------------------
    // One clock domain, reset disables all checks
    // ----------------------------------------------------------
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    // Reset request: fixed width, then released
    sequence s_rst_high;
        system_reset_request [*4];
    endsequence
    sequence s_rst_end;
        !system_reset_request;
    endsequence
    property p_rst_pulse;
        $rose(system_reset_request) |-> s_rst_high ##1 s_rst_end;
    endproperty
    a_rst_pulse: assert property (p_rst_pulse)
        else $error("reset request width wrong");
    property p_fault;
        access_misaligned |=> hard_fault_exception;
    endproperty
    a_fault: assert property (p_fault)
        else $error("misaligned access without fault");
    property p_wake_ext;
        wait_for_event && external_event |=> wake;
    endproperty
    a_wake_ext: assert property (p_wake_ext)
        else $error("external event did not wake");
    property p_wake_sev;
        wait_for_event && send_event_instruction |=> wake;
    endproperty
    a_wake_sev: assert property (p_wake_sev)
        else $error("send event did not wake");
    property p_wake_pend;
        wait_for_event && irq_pending_enabled |=> wake;
    endproperty
    a_wake_pend: assert property (p_wake_pend)
        else $error("pending interrupt did not wake");
    property p_no_wake;
        !wait_for_event |=> !wake;
    endproperty
    a_no_wake: assert property (p_no_wake)
        else $error("wake while not waiting");
    property p_one_mode;
        !(sleep_req && deep_sleep_req);
    endproperty
    a_one_mode: assert property (p_one_mode)
        else $error("sleep and deep sleep together");
    property p_sleep_cause;
        sleep_req || deep_sleep_req |-> $past(handler_return_to_thread);
    endproperty
    a_sleep_cause: assert property (p_sleep_cause)
        else $error("sleep without handler return");
    property p_pad;
        exc_entry |=> stacked_align_pad == $past(sp_bit2);
    endproperty
    a_pad: assert property (p_pad)
        else $error("alignment padding not recorded");
endmodule : scr_regs_properties
bind scr_regs scr_regs_properties scr_regs_properties_inst (
    .hclk, .hresetn, .wait_for_event, .irq_pending_enabled,
    .send_event_instruction, .external_event, .handler_return_to_thread,
    .exc_entry, .sp_bit2, .access_misaligned, .wake, .sleep_req,
    .deep_sleep_req, .system_reset_request, .hard_fault_exception,
    .stacked_align_pad
);
`default_nettype wire

// ===== dv/tb_top.sv
// Self-checking bench for the system control register bank
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic [2:0]  hsize = 3'h2;
    logic        sp_bit2 = 1'b0, stacked_psr_bit9 = 1'b0;
    logic [8:0]  side = 9'h0;
    logic [31:0] m_vt = 32'h0, m_lp = 32'h0, m_p2 = 32'h0, m_p3 = 32'h0;
    int          seed = 98674, bad_count = 0, checked = 0, cyc = 0;
    logic [7:0]  addr_tab [7] = '{scr_pkg::VTBO_OFF, scr_pkg::AIRC_OFF,
        scr_pkg::LPC_OFF, scr_pkg::CFG_OFF, scr_pkg::HPR2_OFF,
        scr_pkg::HPR3_OFF, 8'h24};
    wire logic [31:0] hrdata, vector_table_base;
    wire logic [1:0]  supervisor_call_priority, pendable_service_priority;
    wire logic [1:0]  tick_timer_priority;
    wire logic hreadyout, hresp, wake, event_latched, sleep_req, hready;
    wire logic deep_sleep_req, system_reset_request, hard_fault_exception;
    wire logic stacked_align_pad, return_align_pad, wait_for_event;
    wire logic irq_pending_enabled, irq_pending_disabled, external_event;
    wire logic send_event_instruction, handler_return_to_thread;
    wire logic exc_entry, exc_return, access_misaligned;

    // Side-band inputs packed so one pulse task drives them all
    assign {wait_for_event, irq_pending_enabled, irq_pending_disabled,
        send_event_instruction, external_event, handler_return_to_thread,
        exc_entry, exc_return, access_misaligned} = side;
    assign hready = hreadyout; // single slave on the bus

    scr_regs scr_regs_inst (.*);

    always #5 hclk = ~hclk;

    // Cycle ceiling so a stuck handshake still ends the run
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            bad_count = bad_count + 1;
            end_of_test();
        end
    end

    task automatic end_of_test();
        $display("checked %0d bad_count %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : end_of_test

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        checked = checked + 1;
        if (g !== e) begin
            bad_count = bad_count + 1;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // One single AHB transfer; address held until hready seen high
    task automatic xfer(input logic [7:0] a, input logic w,
                        input logic [2:0] s, input logic [31:0] d,
                        output logic [31:0] r);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= scr_pkg::HTRANS_NSEQ;
        hwrite <= w;
        hsize <= s;
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        r = hrdata;
    endtask : xfer

    // Side-band inputs high for one cycle, outputs settled on return
    task automatic pulse(input logic [8:0] v);
        @(posedge hclk);
        side <= v;
        @(posedge hclk);
        side <= 9'h0;
        #1;
    endtask : pulse

    function automatic logic [31:0] exp_rd(input logic [7:0] a);
        case (a)
            scr_pkg::VTBO_OFF: exp_rd = m_vt;
            scr_pkg::LPC_OFF:  exp_rd = m_lp;
            scr_pkg::CFG_OFF:  exp_rd = 32'h0000_0208;
            scr_pkg::HPR2_OFF: exp_rd = m_p2;
            scr_pkg::HPR3_OFF: exp_rd = m_p3;
            default:           exp_rd = 32'h0;
        endcase
    endfunction : exp_rd

    // Shadow copy; narrow priority writes are dropped
    function automatic void model_wr(input logic [7:0] a,
                                     input logic [2:0] s,
                                     input logic [31:0] d);
        case (a)
            scr_pkg::VTBO_OFF: m_vt = d & 32'hffff_ff80;
            scr_pkg::LPC_OFF:  m_lp = d & 32'h0000_0016;
            scr_pkg::HPR2_OFF: if (s == 3'h2) m_p2 = d & 32'hc000_0000;
            scr_pkg::HPR3_OFF: if (s == 3'h2) m_p3 = d & 32'hc0c0_0000;
            default: ;
        endcase
    endfunction : model_wr

    initial begin : main
        logic [31:0] r, d;
        logic [7:0]  a;
        logic [2:0]  s;
        int          cnt;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        // Reset values and fixed fields
        foreach (addr_tab[i]) begin
            xfer(addr_tab[i], 1'b0, 3'h2, 32'h0, r);
            chk("reset_read", exp_rd(addr_tab[i]), r);
        end
        // Random writes, each read straight back
        repeat (60) begin
            a = addr_tab[$unsigned($random(seed)) % 7];
            d = $random(seed);
            s = scr_pkg::HSIZE_WORD;
            if (a == scr_pkg::AIRC_OFF)
                d = d & 32'hffff_fff9;
            xfer(a, 1'b1, s, d, r);
            model_wr(a, s, d);
            xfer(a, 1'b0, 3'h2, 32'h0, r);
            chk("readback", exp_rd(a), r);
        end
        chk("vector_table_base", m_vt, vector_table_base);
        chk("priorities", {26'h0, m_p2[31:30], m_p3[31:30], m_p3[23:22]},
            {26'h0, supervisor_call_priority, tick_timer_priority,
             pendable_service_priority});
        chk("hresp", 32'h0, {31'h0, hresp});
        // Reset request with a wrong key, then with the right one
        for (int k = 0; k < 2; k++) begin
            d = {k ? scr_pkg::WRITE_KEY : 16'h05fb, 16'h0004};
            xfer(scr_pkg::AIRC_OFF, 1'b1, 3'h2, d, r);
            cnt = 0;
            repeat (10) begin
                @(posedge hclk);
                #1;
                if (system_reset_request === 1'b1)
                    cnt++;
            end
            chk("reset_pulse", k ? 32'(scr_pkg::RST_PULSE_CYC) : 0,
                cnt);
        end
        // Each wake source, with and without event on pending
        for (int e = 0; e < 2; e++) begin
            d = e ? 32'h10 : 32'h0;
            xfer(scr_pkg::LPC_OFF, 1'b1, 3'h2, d, r);
            model_wr(scr_pkg::LPC_OFF, 3'h2, d);
            for (int i = 4; i < 8; i++) begin
                pulse(9'h100);
                pulse(9'h100 | (9'h1 << i));
                chk("wake", (i == 6) ? e : 1, {31'h0, wake});
            end
        end
        // Event while running is held for the next wait
        pulse(9'h010);
        chk("event_latched", 1, {31'h0, event_latched});
        pulse(9'h100);
        chk("wake_latched", 1, {31'h0, wake});
        pulse(9'h100);
        chk("wake_consumed", 0, {31'h0, wake});
        // Sleep on handler return, every mode combination
        for (int j = 0; j < 4; j++) begin
            d = {29'h0, j[1:0], 1'b0};
            xfer(scr_pkg::LPC_OFF, 1'b1, 3'h2, d, r);
            pulse(9'h008);
            chk("sleep_req", d[1] & !d[2], {31'h0, sleep_req});
            chk("deep_sleep_req", d[1] & d[2],
                {31'h0, deep_sleep_req});
        end
        // Stack padding record and misaligned fault
        repeat (8) begin
            d = $random(seed);
            @(posedge hclk);
            sp_bit2 <= d[0];
            stacked_psr_bit9 <= d[1];
            pulse(9'h004);
            chk("stacked_align_pad", d[0],
                {31'h0, stacked_align_pad});
            pulse({7'h0, 1'b1, d[2]});
            chk("return_align_pad", d[1], {31'h0, return_align_pad});
            chk("hard_fault", d[2], {31'h0, hard_fault_exception});
        end
        end_of_test();
    end
endmodule : tb_top
`default_nettype wire
